// file: core/ivm_pkg.sv
// Shared constants, types and source layout of the interrupt vector map
package ivm_pkg;

   // Vector area spans the top of the 64K space, two bytes per slot
   localparam logic [15:0] VEC_BASE   = 16'hffcc;  // Lowest slot, even byte
   localparam logic [15:0] VEC_TOP    = 16'hffff;  // Last byte of reset slot
   localparam int          SLOT_NUM   = 26;        // Two-byte slots in the area
   localparam int          SLOT_W     = 5;         // Width of a slot index
   localparam int          SRC_NUM    = 26;        // Interrupt sources, no reset
   localparam logic [4:0]  SLOT_RESET = 5'h19;     // Topmost slot
   localparam logic [4:0]  SLOT_SWI   = 5'h18;     // Slot under the reset slot

   // Variant selection codes
   localparam logic VARIANT_FIRST  = 1'b0;         // Layout with network ports
   localparam logic VARIANT_SECOND = 1'b1;         // Layout with byte data link

   // Values after reset
   localparam logic        RESET_PEND_INIT = 1'b1; // Reset vector owed at start
   localparam logic [15:0] ADDR_INIT       = 16'h0000;
   localparam logic [4:0]  SLOT_INIT       = 5'h00;

   // Source identities; the value is the bit position in the pending word
   typedef enum logic [4:0] {
      SRC_TA_CH0  = 5'h00, SRC_TA_CH1  = 5'h01, SRC_TA_CH2  = 5'h02,
      SRC_TA_CH3  = 5'h03, SRC_TA_CH4  = 5'h04, SRC_TA_CH5  = 5'h05,
      SRC_TA_OVF  = 5'h06, SRC_TB_CH0  = 5'h07, SRC_TB_CH1  = 5'h08,
      SRC_TB_OVF  = 5'h09, SRC_CONV    = 5'h0a, SRC_KEYB    = 5'h0b,
      SRC_AS_TX   = 5'h0c, SRC_AS_RX   = 5'h0d, SRC_AS_ERR  = 5'h0e,
      SRC_CAN_TX  = 5'h0f, SRC_CAN_RX  = 5'h10, SRC_CAN_ERR = 5'h11,
      SRC_CAN_WK  = 5'h12, SRC_SS_TX   = 5'h13, SRC_SS_RX   = 5'h14,
      SRC_PIT     = 5'h15, SRC_BDL     = 5'h16, SRC_CLKSYN  = 5'h17,
      SRC_EXTPIN  = 5'h18, SRC_SWI     = 5'h19, SRC_RESET   = 5'h1a,
      SRC_NONE    = 5'h1b
   } ivm_src_t;

   // Pending requests; field order puts each source at its enum bit
   typedef struct packed {
      logic software_interrupt;
      logic external_interrupt_pin;
      logic clock_synth;
      logic byte_data_link;
      logic periodic_interrupt_timer;
      logic sync_serial_rx;
      logic sync_serial_tx;
      logic can_wakeup;
      logic can_error;
      logic can_rx;
      logic can_tx;
      logic async_serial_port_error;
      logic async_serial_port_rx;
      logic async_serial_port_tx;
      logic keyboard;
      logic converter;
      logic timer_b_overflow;
      logic timer_b_ch1;
      logic timer_b_ch0;
      logic timer_a_overflow;
      logic timer_a_ch5;
      logic timer_a_ch4;
      logic timer_a_ch3;
      logic timer_a_ch2;
      logic timer_a_ch1;
      logic timer_a_ch0;
   } ivm_pend_t;

   // Main sequencer states, Gray along idle-resolve-fetch-finish
   typedef enum logic [1:0] {
      ST_IDLE    = 2'h0,
      ST_RESOLVE = 2'h1,
      ST_FETCH   = 2'h3,
      ST_FINISH  = 2'h2
   } ivm_state_t;

   // Byte fetch states, Gray along idle-high-low
   typedef enum logic [1:0] {
      FS_IDLE = 2'h0,
      FS_HIGH = 2'h1,
      FS_LOW  = 2'h3
   } ivm_fstate_t;

endpackage

// file: core/ivm_prio_enc.sv
// Fixed-priority encoder: the highest set bit wins
`timescale 1ns/1ps
`default_nettype none
module ivm_prio_enc #(
   parameter int W  = 26,
   parameter int IW = 5
) (
   input  wire logic [W-1:0]  req,
   output logic      [IW-1:0] idx,
   output logic               any
);

   // Scan upward so a later (higher) bit overrides a lower one
   always_comb begin
      idx = '0;
      any = 1'b0;
      for (int i = 0; i < W; i++) begin
         if (req[i]) begin
            idx = IW'(i);
            any = 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// file: core/ivm_fetch_seq.sv
// Two-beat sequencer presenting the high then the low vector byte address
`timescale 1ns/1ps
`default_nettype none
module ivm_fetch_seq (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [15:0] base_addr,
   input  wire logic        byte_ready,
   output logic             byte_valid,
   output logic             byte_low,
   output logic      [15:0] byte_addr,
   output logic             done
);

   ivm_pkg::ivm_fstate_t st_q;        // Beat state
   ivm_pkg::ivm_fstate_t st_d;        // Next beat state
   logic          [15:0] addr_q;      // Byte address on offer
   logic          [15:0] addr_d;      // Next byte address

   // Handshake outputs follow the state
   assign byte_valid = (st_q != ivm_pkg::FS_IDLE);
   assign byte_low   = (st_q == ivm_pkg::FS_LOW);
   assign done       = (st_q == ivm_pkg::FS_LOW) && byte_ready;
   assign byte_addr  = addr_q;

   // Next state: high byte at the even address first, then the odd one
   always_comb begin
      st_d   = st_q;
      addr_d = addr_q;
      unique case (st_q)
         ivm_pkg::FS_IDLE: begin
            if (start) begin
               st_d   = ivm_pkg::FS_HIGH;
               addr_d = {base_addr[15:1], 1'b0};
            end
         end
         ivm_pkg::FS_HIGH: begin
            if (byte_ready) begin
               st_d   = ivm_pkg::FS_LOW;
               addr_d = {addr_q[15:1], 1'b1};
            end
         end
         ivm_pkg::FS_LOW: begin
            if (byte_ready) begin
               st_d = ivm_pkg::FS_IDLE;
            end
         end
         // Unused code falls back to idle
         default: begin
            st_d = ivm_pkg::FS_IDLE;
         end
      endcase
   end

   // State and address registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q   <= ivm_pkg::FS_IDLE;
         addr_q <= ivm_pkg::ADDR_INIT;
      end else begin
         st_q   <= st_d;
         addr_q <= addr_d;
      end
   end

endmodule
`default_nettype wire

// file: core/interrupt_vector_map.sv
// Interrupt vector address generator with fixed priority and two layouts
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_map #(
   parameter int SLOTS  = ivm_pkg::SLOT_NUM,
   parameter int SLOT_W = ivm_pkg::SLOT_W
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 variant_sel,
   input  wire ivm_pkg::ivm_pend_t   src_pend,
   input  wire logic                 irq_masked,
   input  wire logic                 reset_req,
   input  wire logic                 vec_req,
   input  wire logic                 byte_ready,
   output logic                      busy,
   output logic                      vec_done,
   output logic                      vec_none,
   output logic               [15:0] vec_addr,
   output ivm_pkg::ivm_src_t         vec_src,
   output logic                      byte_valid,
   output logic                      byte_low,
   output logic               [15:0] byte_addr
);

   // Source held by a slot in a layout; reserved slots give no source
   function automatic ivm_pkg::ivm_src_t slot_src(
      input logic       second,
      input logic [4:0] slot
   );
      ivm_pkg::ivm_src_t r;
      r = ivm_pkg::SRC_NONE;
      case (slot)
         // Bottom of the area: reserved in the second layout
         5'h00: r = second ? ivm_pkg::SRC_NONE   : ivm_pkg::SRC_TA_CH5;
         5'h01: r = second ? ivm_pkg::SRC_NONE   : ivm_pkg::SRC_TA_CH4;
         5'h02: r = second ? ivm_pkg::SRC_NONE   : ivm_pkg::SRC_CONV;
         // Keyboard is shared by both layouts
         5'h03: r = ivm_pkg::SRC_KEYB;
         // Three slots over the keyboard, reserved in the second layout
         5'h04: r = second ? ivm_pkg::SRC_NONE   : ivm_pkg::SRC_AS_TX;
         5'h05: r = second ? ivm_pkg::SRC_NONE   : ivm_pkg::SRC_AS_RX;
         5'h06: r = second ? ivm_pkg::SRC_NONE   : ivm_pkg::SRC_AS_ERR;
         // Middle band: network controller, sync serial and timer B, or second-layout peripherals
         5'h07: r = second ? ivm_pkg::SRC_PIT    : ivm_pkg::SRC_CAN_TX;
         5'h08: r = second ? ivm_pkg::SRC_BDL    : ivm_pkg::SRC_CAN_RX;
         5'h09: r = second ? ivm_pkg::SRC_CONV   : ivm_pkg::SRC_CAN_ERR;
         5'h0a: r = second ? ivm_pkg::SRC_AS_TX  : ivm_pkg::SRC_CAN_WK;
         5'h0b: r = second ? ivm_pkg::SRC_AS_RX  : ivm_pkg::SRC_SS_TX;
         5'h0c: r = second ? ivm_pkg::SRC_AS_ERR : ivm_pkg::SRC_SS_RX;
         5'h0d: r = second ? ivm_pkg::SRC_SS_TX  : ivm_pkg::SRC_TB_OVF;
         5'h0e: r = second ? ivm_pkg::SRC_SS_RX  : ivm_pkg::SRC_TB_CH1;
         5'h0f: r = second ? ivm_pkg::SRC_TA_OVF : ivm_pkg::SRC_TB_CH0;
         // Timer A band; the first layout puts PIT in its top slot
         5'h10: r = second ? ivm_pkg::SRC_TA_CH5 : ivm_pkg::SRC_TA_OVF;
         5'h11: r = second ? ivm_pkg::SRC_TA_CH4 : ivm_pkg::SRC_TA_CH3;
         5'h12: r = second ? ivm_pkg::SRC_TA_CH3 : ivm_pkg::SRC_TA_CH2;
         5'h13: r = second ? ivm_pkg::SRC_TA_CH2 : ivm_pkg::SRC_TA_CH1;
         5'h14: r = second ? ivm_pkg::SRC_TA_CH1 : ivm_pkg::SRC_TA_CH0;
         5'h15: r = second ? ivm_pkg::SRC_TA_CH0 : ivm_pkg::SRC_PIT;
         // Shared top four slots
         5'h16: r = ivm_pkg::SRC_CLKSYN;
         5'h17: r = ivm_pkg::SRC_EXTPIN;
         5'h18: r = ivm_pkg::SRC_SWI;
         5'h19: r = ivm_pkg::SRC_RESET;
         // Indices past the area hold nothing
         default: r = ivm_pkg::SRC_NONE;
      endcase
      return r;
   endfunction

   // Even address of a slot in the vector area
   function automatic logic [15:0] slot_addr(input logic [4:0] slot);
      return ivm_pkg::VEC_BASE + {10'h000, slot, 1'b0};
   endfunction

   localparam int SSRC_TOP = ivm_pkg::SRC_NUM;  // Bit of the reset request

   ivm_pkg::ivm_state_t   st_q;          // Sequencer state
   ivm_pkg::ivm_state_t   st_d;          // Next sequencer state
   logic                  variant_q;     // Captured layout select
   logic                  strap_done_q;  // Layout select has been caught
   logic                  reset_pend_q;  // Reset vector still owed
   logic                  reset_pend_d;  // Next reset-owed flag
   logic     [SLOT_W-1:0] slot_q;        // Winning slot of this request
   logic                  none_q;        // Nothing was pending at the request
   logic           [15:0] addr_q;        // Answered vector address
   ivm_pkg::ivm_src_t     src_q;         // Answered source
   logic  [SSRC_TOP:0]    eff_pend;      // Pending after masking, reset on top
   logic      [SLOTS-1:0] slot_act;      // Slot has a live request
   logic     [SLOT_W-1:0] win_slot;      // Highest live slot now
   logic                  win_any;       // Some slot is live now
   logic                  take_req;      // Request accepted this edge
   logic                  fetch_start;   // Launch the two byte beats
   logic                  fetch_done;    // Low byte taken
   logic           [15:0] fetch_base;    // Address handed to the sequencer

   // Masked sources drop out; the software vector ignores the mask
   assign eff_pend[ivm_pkg::SRC_NUM-1:0] =
      irq_masked ? (src_pend & ivm_pkg::ivm_pend_t'({1'b1, 25'h0}))
                 : src_pend;
   assign eff_pend[SSRC_TOP] = reset_pend_q;

   // Per-slot live flag under the captured layout
   generate
      for (genvar s = 0; s < SLOTS; s++) begin : g_slot
         ivm_pkg::ivm_src_t sid;              // Source in this slot
         assign sid = slot_src(variant_q, 5'(s));
         // A reserved slot maps to no source and stays dead
         assign slot_act[s] = (sid != ivm_pkg::SRC_NONE) && eff_pend[sid];
      end
   endgenerate

   // Highest slot wins; reset owns the top slot so it overrides all
   ivm_prio_enc #(
      .W  (SLOTS),
      .IW (SLOT_W)
   ) u_prio (
      .req (slot_act),
      .idx (win_slot),
      .any (win_any)
   );

   // A request is taken only when idle and the layout is known
   assign take_req    = vec_req && (st_q == ivm_pkg::ST_IDLE) && strap_done_q;
   assign fetch_start = (st_q == ivm_pkg::ST_RESOLVE);
   assign fetch_base  = addr_q;

   // Byte beats toward the core
   ivm_fetch_seq u_fetch (
      .clk        (clk),
      .rst        (rst),
      .start      (fetch_start),
      .base_addr  (fetch_base),
      .byte_ready (byte_ready),
      .byte_valid (byte_valid),
      .byte_low   (byte_low),
      .byte_addr  (byte_addr),
      .done       (fetch_done)
   );

   // Sequencer: resolve, fetch two bytes, report
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ivm_pkg::ST_IDLE: begin
            // With nothing pending the answer comes at once
            if (take_req) begin
               st_d = win_any ? ivm_pkg::ST_RESOLVE : ivm_pkg::ST_FINISH;
            end
         end
         ivm_pkg::ST_RESOLVE: begin
            st_d = ivm_pkg::ST_FETCH;
         end
         ivm_pkg::ST_FETCH: begin
            if (fetch_done) begin
               st_d = ivm_pkg::ST_FINISH;
            end
         end
         ivm_pkg::ST_FINISH: begin
            st_d = ivm_pkg::ST_IDLE;
         end
      endcase
   end

   // Reset owed: a new request wins over the clear after serving it
   always_comb begin
      reset_pend_d = reset_pend_q;
      if ((st_q == ivm_pkg::ST_FINISH) && !none_q &&
          (slot_q == ivm_pkg::SLOT_RESET)) begin
         reset_pend_d = 1'b0;
      end
      if (reset_req) begin
         reset_pend_d = 1'b1;
      end
   end

   // State and reset-owed flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q         <= ivm_pkg::ST_IDLE;
         reset_pend_q <= ivm_pkg::RESET_PEND_INIT;
      end else begin
         st_q         <= st_d;
         reset_pend_q <= reset_pend_d;
      end
   end

   // Layout select is caught once, on the first edge after release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         variant_q    <= ivm_pkg::VARIANT_FIRST;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         variant_q    <= variant_sel;
         strap_done_q <= 1'b1;
      end
   end

   // Winner is frozen on the accepting edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_q <= ivm_pkg::SLOT_INIT;
         none_q <= 1'b0;
      end else if (take_req) begin
         slot_q <= win_slot;
         none_q <= !win_any;
      end
   end

   // Address and source of the frozen winner
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q <= ivm_pkg::ADDR_INIT;
         src_q  <= ivm_pkg::SRC_NONE;
      end else if (take_req) begin
         addr_q <= win_any ? slot_addr(win_slot) : ivm_pkg::ADDR_INIT;
         src_q  <= win_any ? slot_src(variant_q, win_slot) : ivm_pkg::SRC_NONE;
      end
   end

   // Status toward the core
   assign busy     = (st_q != ivm_pkg::ST_IDLE) || !strap_done_q;
   assign vec_done = (st_q == ivm_pkg::ST_FINISH);
   assign vec_none = none_q;
   assign vec_addr = addr_q;
   assign vec_src  = src_q;

endmodule
`default_nettype wire

// file: sim/ivm_monitor.sv
// Port-level property checker for the interrupt vector map
`timescale 1ns/1ps
`default_nettype none
module ivm_monitor (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               variant_sel,
   input wire ivm_pkg::ivm_pend_t src_pend,
   input wire logic               irq_masked,
   input wire logic               reset_req,
   input wire logic               vec_req,
   input wire logic               byte_ready,
   input wire logic               busy,
   input wire logic               vec_done,
   input wire logic               vec_none,
   input wire logic        [15:0] vec_addr,
   input wire logic         [4:0] vec_src,
   input wire logic               byte_valid,
   input wire logic               byte_low,
   input wire logic        [15:0] byte_addr
);
   // One clock domain; every check rests while reset is high
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Request taken by the sequencer
   sequence s_take; vec_req && !busy; endsequence
   // High byte handed over to the core
   sequence s_hi_beat; byte_valid && !byte_low && byte_ready; endsequence
   property p_pair;
      s_hi_beat |=> byte_valid && byte_low && byte_addr == $past(byte_addr) + 16'h0001;
   endproperty
   a_pair: assert property (p_pair) else $error("low byte not at odd address");
   property p_hi_even;
      byte_valid && !byte_low |-> byte_addr == vec_addr && !byte_addr[0];
   endproperty
   a_hi_even: assert property (p_hi_even) else $error("high byte not even");
   property p_top;
      vec_done && !vec_none |-> vec_addr >= 16'hffcc && !vec_addr[0];
   endproperty
   a_top: assert property (p_top) else $error("vector outside top area");
   property p_walk;
      s_take ##1 !vec_none |=> s_hi_beat or (byte_valid && !byte_low);
   endproperty
   a_walk: assert property (p_walk) else $error("fetch did not start");
   property p_bound; s_take |-> ##[1:40] vec_done; endproperty
   a_bound: assert property (p_bound) else $error("no answer in time");
   property p_reset;
      vec_done && vec_src == ivm_pkg::SRC_RESET |-> vec_addr == 16'hfffe;
   endproperty
   a_reset: assert property (p_reset) else $error("reset vector misplaced");
   property p_swi;
      vec_done && vec_src == ivm_pkg::SRC_SWI |-> vec_addr == 16'hfffc;
   endproperty
   a_swi: assert property (p_swi) else $error("software vector misplaced");
   property p_swi_wins;
      s_take and src_pend.software_interrupt |=>
         vec_src inside {ivm_pkg::SRC_SWI, ivm_pkg::SRC_RESET};
   endproperty
   a_swi_wins: assert property (p_swi_wins) else $error("lower source beat software");
   property p_mask;
      s_take and irq_masked && !src_pend.software_interrupt |=>
         vec_src inside {ivm_pkg::SRC_RESET, ivm_pkg::SRC_NONE};
   endproperty
   a_mask: assert property (p_mask) else $error("masked source answered");
   property p_reserved;
      vec_done && variant_sel && !vec_none |-> vec_addr == 16'hffd2 || vec_addr >= 16'hffda;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved slot chosen");
   property p_pulse; vec_done |=> !vec_done; endproperty
   a_pulse: assert property (p_pulse) else $error("answer longer than a cycle");
endmodule
bind interrupt_vector_map ivm_monitor mon_u (.clk, .rst, .variant_sel, .src_pend, .irq_masked,
   .reset_req, .vec_req, .byte_ready, .busy, .vec_done, .vec_none, .vec_addr, .vec_src,
   .byte_valid, .byte_low, .byte_addr);
`default_nettype wire

// file: sim/ivm_cpu_model.sv
// Core-side model: asks for a vector and fetches both bytes
`timescale 1ns/1ps
`default_nettype none
module ivm_cpu_model (
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         start,
   input wire logic         slow,
   input wire logic         busy,
   input wire logic         byte_valid,
   input wire logic         byte_low,
   input wire logic  [15:0] byte_addr,
   output logic             vec_req,
   output logic             byte_ready,
   output logic      [15:0] hi_q,
   output logic      [15:0] lo_q,
   output logic      [1:0]  beats_q
);
   // Request held until taken; slow mode stalls every other cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vec_req    <= 1'b0;
         byte_ready <= 1'b0;
         hi_q       <= 16'h0000;
         lo_q       <= 16'h0000;
         beats_q    <= 2'h0;
      end else begin
         byte_ready <= slow ? ~byte_ready : 1'b1;
         if (start) begin
            vec_req <= 1'b1;
            beats_q <= 2'h0;
         end else if (vec_req && !busy) begin
            vec_req <= 1'b0;
         end
         // Capture each byte address as it is accepted
         if (byte_valid && byte_ready) begin
            beats_q <= beats_q + 2'h1;
            if (byte_low) lo_q <= byte_addr;
            else hi_q <= byte_addr;
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the interrupt vector map
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {logic [4:0] src; logic [4:0] s0; logic [4:0] s1;} ivm_row_t;
   logic clk, rst, var_q, masked, rreq, start, slow, vreq, rdy, busy, done, none, bv, bl;
   logic [15:0] vaddr, baddr, hi, lo;
   logic [4:0]  vsrc;
   logic [1:0]  beats;
   logic [25:0] pend;
   int          bad_count, tests_run;
   // Source bit, slot in first layout, slot in second; 1f means absent
   ivm_row_t rows [26] = '{'{5'h00,5'h14,5'h15}, '{5'h01,5'h13,5'h14}, '{5'h02,5'h12,5'h13},
      '{5'h03,5'h11,5'h12}, '{5'h04,5'h01,5'h11}, '{5'h05,5'h00,5'h10}, '{5'h06,5'h10,5'h0f},
      '{5'h07,5'h0f,5'h1f}, '{5'h08,5'h0e,5'h1f}, '{5'h09,5'h0d,5'h1f}, '{5'h0a,5'h02,5'h09},
      '{5'h0b,5'h03,5'h03}, '{5'h0c,5'h04,5'h0a}, '{5'h0d,5'h05,5'h0b}, '{5'h0e,5'h06,5'h0c},
      '{5'h0f,5'h07,5'h1f}, '{5'h10,5'h08,5'h1f}, '{5'h11,5'h09,5'h1f}, '{5'h12,5'h0a,5'h1f},
      '{5'h13,5'h0b,5'h0d}, '{5'h14,5'h0c,5'h0e}, '{5'h15,5'h15,5'h07}, '{5'h16,5'h1f,5'h08},
      '{5'h17,5'h16,5'h16}, '{5'h18,5'h17,5'h17}, '{5'h19,5'h18,5'h18}};
   interrupt_vector_map dut_u (.clk(clk), .rst(rst), .variant_sel(var_q),
      .src_pend(ivm_pkg::ivm_pend_t'(pend)), .irq_masked(masked), .reset_req(rreq),
      .vec_req(vreq), .byte_ready(rdy), .busy(busy), .vec_done(done), .vec_none(none),
      .vec_addr(vaddr), .vec_src(vsrc), .byte_valid(bv), .byte_low(bl), .byte_addr(baddr));
   ivm_cpu_model cpu_u (.clk(clk), .rst(rst), .start(start), .slow(slow), .busy(busy),
      .byte_valid(bv), .byte_low(bl), .byte_addr(baddr), .vec_req(vreq), .byte_ready(rdy),
      .hi_q(hi), .lo_q(lo), .beats_q(beats));
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Source in the highest live slot among pending sources for the current layout, 1b if none
   function automatic logic [4:0] best(input logic [25:0] p);
      logic [4:0] b, s, bs;
      b = 5'h1b;
      bs = 5'h00;
      for (int k = 0; k < 26; k++) begin
         s = var_q ? rows[k].s1 : rows[k].s0;
         if (p[k] && s != 5'h1f && (!masked || k == 25) && (b == 5'h1b || s > bs)) begin
            b = k[4:0];
            bs = s;
         end
      end
      return b;
   endfunction
   // One vector request; expected address derived from the source table
   task fetch(input logic [4:0] es);
      logic [15:0] ea;
      int n;
      n = 0;
      ea = es == 5'h1b ? 16'h0000 : es == 5'h1a ? 16'hfffe :
         16'hffcc + {10'h000, var_q ? rows[es].s1 : rows[es].s0, 1'b0};
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      while (done !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      // A request that never answers ends the run as a failure
      if (n >= 50) begin
         bad_count++;
         end_sim;
      end
      chk("vec_addr", vaddr, ea);
      chk("vec_src", {11'h000, vsrc}, {11'h000, es});
      chk("vec_none", {15'h0000, none}, {15'h0000, es == 5'h1b});
      chk("beats", {14'h0000, beats}, es == 5'h1b ? 16'h0000 : 16'h0002);
      if (es != 5'h1b) chk("hi", hi, ea);
      if (es != 5'h1b) chk("lo", lo, ea + 16'h0001);
   endtask
   task end_sim;
      $display("tests_run %0d bad_count %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Hang guard
   initial begin
      #100000;
      bad_count++;
      end_sim;
   end
   initial begin
      bad_count = 0;
      tests_run = 0;
      {rst, var_q, masked, rreq, start, slow, pend} = {1'b1, 31'h0};
      for (int v = 0; v < 2; v++) begin
         @(negedge clk);
         rst = 1'b1;
         var_q = v[0];
         slow = v[0];
         masked = 1'b0;
         pend = 26'h0;
         repeat (4) @(negedge clk);
         rst = 1'b0;
         fetch(5'h1a);
         foreach (rows[i]) begin
            pend = 26'h1 << rows[i].src;
            fetch(best(pend));
         end
         $display("single sources done, layout %0d", v);
         pend = 26'h3ffffff;
         while (pend != 26'h0) begin
            fetch(best(pend));
            pend[best(pend)] = 1'b0;
            if (best(pend) == 5'h1b) pend = 26'h0;
         end
         fetch(5'h1b);
         $display("priority walk done, layout %0d", v);
      end
      pend = 26'h3ffffff;
      masked = 1'b1;
      fetch(5'h19);
      pend[25] = 1'b0;
      fetch(5'h1b);
      masked = 1'b0;
      rreq = 1'b1;
      @(negedge clk);
      rreq = 1'b0;
      fetch(5'h1a);
      fetch(best(pend));
      $display("mask and reset override done");
      end_sim;
   end
endmodule
`default_nettype wire
